/* File: logic/reset_source_combiner.sv */
// reset source combiner top
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"
module reset_source_combiner (
    // clock and power-up reset
    input wire logic mclk,
    input wire logic rst,
    // causes and their enables
    input wire logic supplyLow,
    input wire logic resetPinN,
    input wire logic watchdogExpire,
    input wire logic watchdogEnable,
    input wire logic lowSupplyCmp,
    input wire logic lowSupplyEnable,
    // fuses
    input wire logic [`RSC_FUSE_SUT_W-1:0] startupTimeFuses,
    input wire logic [`RSC_FUSE_CLOCK_SELECT_FUSES_W-1:0] clockSelectFuses,
    // flag clear, one bit per flag, pulse
    input wire logic [3:0] flagClear,
    // results
    output logic internalReset,
    output logic portResetN,
    output logic [3:0] resetCauseStatus
);
    // three-stage sync of analog and pin causes
    logic [2:0] supS, pinS, lowS;
    logic supF, pinLowF, lowF;
    logic [`RSC_CNT_W-1:0] pinCnt, next_pinCnt;
    logic pinHit, next_pinHit;
    logic wdgPulse, next_wdgPulse, wdgPrev;
    logic [`RSC_CNT_W-1:0] dly, next_dly;
    logic [`RSC_CNT_W-1:0] tout;
    rsc_pkg::rsc_state_t st, next_st;
    logic anyCause, lowCause, supCause;
    logic next_irst;
    logic [3:0] flagsOut;
    rsc_flags_if fif ();

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            supS <= 3'h7;
            pinS <= 3'h0;
            lowS <= 3'h0;
            supF <= 1'b1;
            pinLowF <= 1'b0;
            lowF <= 1'b0;
        end else begin
            supS <= {supS[1:0], supplyLow};
            pinS <= {pinS[1:0], ~resetPinN};
            lowS <= {lowS[1:0], lowSupplyCmp};
            if (supS[1] == supS[2]) supF <= supS[2];
            if (pinS[1] == pinS[2]) pinLowF <= pinS[2];
            if (lowS[1] == lowS[2]) lowF <= lowS[2];
        end
    end

    // pin must stay low the minimum width before it counts
    always_comb begin
        next_pinCnt = pinCnt;
        next_pinHit = pinHit;
        if (!pinLowF) begin
            next_pinCnt = '0;
            next_pinHit = 1'b0;
        end else if (pinCnt < `RSC_CNT_W'(`RSC_PIN_MIN_CYC)) begin
            next_pinCnt = pinCnt + 1'b1;
        end else begin
            next_pinHit = 1'b1;
        end
        next_wdgPulse = watchdogExpire && !wdgPrev && watchdogEnable;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinCnt <= '0;
            pinHit <= 1'b0;
            wdgPulse <= 1'b0;
            wdgPrev <= 1'b0;
        end else begin
            pinCnt <= next_pinCnt;
            pinHit <= next_pinHit;
            wdgPulse <= next_wdgPulse;
            wdgPrev <= watchdogExpire;
        end
    end

    assign supCause = supF;
    assign lowCause = lowF && lowSupplyEnable;
    assign anyCause = supCause || pinHit || wdgPulse || lowCause;

    // time-out table from fuses
    always_comb begin
        tout = `RSC_TOUT_BASE << (2 * startupTimeFuses + clockSelectFuses[1:0]);
    end

    always_comb begin
        next_st = st;
        next_dly = dly;
        next_irst = internalReset;
        case (st)
            rsc_pkg::RSC_HOLD: begin
                next_irst = 1'b1;
                next_dly = '0;
                if (!anyCause) begin
                    next_st = rsc_pkg::RSC_STRETCH;
                end
            end
            rsc_pkg::RSC_STRETCH: begin
                next_irst = 1'b1;
                if (anyCause) begin
                    next_st = rsc_pkg::RSC_HOLD;
                    next_dly = '0;
                end else if (dly >= tout - 1'b1) begin
                    next_st = rsc_pkg::RSC_RUN;
                    next_irst = 1'b0;
                end else begin
                    next_dly = dly + 1'b1;
                end
            end
            rsc_pkg::RSC_RUN: begin
                next_irst = 1'b0;
                if (anyCause) begin
                    next_st = rsc_pkg::RSC_HOLD;
                    next_irst = 1'b1;
                end
            end
            default: begin
                next_st = rsc_pkg::RSC_HOLD;
                next_irst = 1'b1;
            end
        endcase
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= rsc_pkg::RSC_HOLD;
            dly <= '0;
            internalReset <= 1'b1;
        end else begin
            st <= next_st;
            dly <= next_dly;
            internalReset <= next_irst;
        end
    end

    // port reset taken asynchronously from rst, the raw supply, pin and low supply causes and the registered watchdog pulse
    logic portAsync;
    assign portAsync = rst || supplyLow || !resetPinN || (lowSupplyCmp && lowSupplyEnable)
        || wdgPulse;
    always_ff @(posedge mclk or posedge portAsync) begin
        if (portAsync) begin
            portResetN <= 1'b0;
        end else begin
            portResetN <= !internalReset;
        end
    end

    assign fif.setFlag = {wdgPulse, lowCause, pinHit, supCause};
    assign fif.clrFlag = flagClear;
    assign fif.supplyClr = supCause;
    assign flagsOut = fif.flags;
    rsc_flags u_flags (
        .mclk(mclk),
        .rst(rst),
        .fl(fif.owner)
    );
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            resetCauseStatus <= `RSC_FLAGS_RST;
        end else begin
            resetCauseStatus <= flagsOut;
        end
    end

    property p_wdg_one;
        @(posedge mclk) disable iff (rst) wdgPulse |=> !wdgPulse;
    endproperty
    a_wdg_one: assert property (p_wdg_one) else $error("watchdog pulse too long");
    property p_run_drop;
        @(posedge mclk) disable iff (rst) (st == rsc_pkg::RSC_RUN && anyCause) |=> internalReset;
    endproperty
    a_run_drop: assert property (p_run_drop) else $error("reset not reasserted");
    property p_hold;
        @(posedge mclk) disable iff (rst) supCause |=> internalReset;
    endproperty
    a_hold: assert property (p_hold) else $error("reset released with supply low");
    property p_stretch;
        @(posedge mclk) disable iff (rst) $fell(anyCause) |=> internalReset [*2];
    endproperty
    a_stretch: assert property (p_stretch) else $error("no stretch");
    property p_restart;
        @(posedge mclk) disable iff (rst) (st == rsc_pkg::RSC_STRETCH && anyCause) |=> dly == 0;
    endproperty
    a_restart: assert property (p_restart) else $error("counter not restarted");
    property p_pinshort;
        @(posedge mclk) disable iff (rst) $rose(pinLowF) |=> !pinHit;
    endproperty
    a_pinshort: assert property (p_pinshort) else $error("pin hit too soon");
    property p_wdg_en;
        @(posedge mclk) disable iff (rst) !$past(watchdogEnable) |-> !wdgPulse;
    endproperty
    a_wdg_en: assert property (p_wdg_en) else $error("watchdog reset while disabled");
    property p_flag;
        @(posedge mclk) disable iff (rst) pinHit |=> ##1 resetCauseStatus[`RSC_FLAG_PIN];
    endproperty
    a_flag: assert property (p_flag) else $error("pin flag not set");
    property p_port;
        @(posedge mclk) disable iff (rst) internalReset |=> !portResetN;
    endproperty
    a_port: assert property (p_port) else $error("port reset released early");
    property p_low_now;
        @(posedge mclk) disable iff (rst) lowCause |=> internalReset;
    endproperty
    a_low_now: assert property (p_low_now) else $error("low supply did not reset");
    property p_sup_flag;
        @(posedge mclk) disable iff (rst) supCause |=> ##1 resetCauseStatus[`RSC_FLAG_SUP];
    endproperty
    a_sup_flag: assert property (p_sup_flag) else $error("supply flag not set");
    property p_wdg_rst;
        @(posedge mclk) disable iff (rst) wdgPulse |=> internalReset;
    endproperty
    a_wdg_rst: assert property (p_wdg_rst) else $error("watchdog did not reset");
    property p_run_free;
        @(posedge mclk) disable iff (rst) st == rsc_pkg::RSC_RUN |-> !internalReset;
    endproperty
    a_run_free: assert property (p_run_free) else $error("reset high in run");
    c_release: cover property (@(posedge mclk) disable iff (rst) $fell(internalReset));
    c_wdg: cover property (@(posedge mclk) disable iff (rst) wdgPulse);
    c_pin: cover property (@(posedge mclk) disable iff (rst) pinHit);
    c_restart: cover property (@(posedge mclk) disable iff (rst)
        st == rsc_pkg::RSC_STRETCH && anyCause);
endmodule
`default_nettype wire

/* File: logic/rsc_flags.sv */
// reset cause flag store
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"
module rsc_flags (
    // clock and power-up reset
    input wire logic mclk,
    input wire logic rst,
    // flags
    rsc_flags_if.owner fl
);
    logic [3:0] flagReg;
    logic [3:0] next_flagReg;
    always_comb begin
        next_flagReg = flagReg;
        for (int i = 0; i < 4; i++) begin
            if (fl.clrFlag[i]) begin
                next_flagReg[i] = 1'b0;
            end
            if (fl.supplyClr && i != `RSC_FLAG_SUP) begin
                next_flagReg[i] = 1'b0;
            end
            if (fl.setFlag[i]) begin
                next_flagReg[i] = 1'b1;
            end
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flagReg <= `RSC_FLAGS_RST;
        end else begin
            flagReg <= next_flagReg;
        end
    end
    assign fl.flags = flagReg;
endmodule
`default_nettype wire

/* File: logic/rsc_flags_if.sv */
// interface carrying flag set and clear strobes
`timescale 1ns/1ps
`default_nettype none
interface rsc_flags_if;
    logic [3:0] setFlag;
    logic [3:0] clrFlag;
    logic supplyClr;
    logic [3:0] flags;
    modport owner (input setFlag, input clrFlag, input supplyClr, output flags);
    modport user (output setFlag, output clrFlag, output supplyClr, input flags);
endinterface
`default_nettype wire

/* File: logic/rsc_map.svh */
// constants for the reset source combiner
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
`define RSC_PIN_MIN_NS 400
`define RSC_CLK_NS 5
`define RSC_PIN_MIN_CYC ((`RSC_PIN_MIN_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_CNT_W 20
`define RSC_TOUT_BASE 20'h0_0010
`define RSC_FUSE_SUT_W 2
`define RSC_FUSE_CLOCK_SELECT_FUSES_W 4
`define RSC_FLAG_SUP 0
`define RSC_FLAG_PIN 1
`define RSC_FLAG_LOW 2
`define RSC_FLAG_WDG 3
`define RSC_FLAGS_RST 4'h0
`endif

/* File: logic/rsc_pkg.sv */
// types for the reset source combiner
package rsc_pkg;
    typedef enum logic [1:0] {
        RSC_HOLD = 2'b00,
        RSC_STRETCH = 2'b01,
        RSC_RUN = 2'b11
    } rsc_state_t;
endpackage

/* File: test/reset_source_combiner_tb.sv */
// testbench for the reset source combiner
`timescale 1ns/1ps
`default_nettype none
module reset_source_combiner_tb;
    logic mclk, rst, wdEn, lsEn, supplyLow, resetPinN, wdExp, lsCmp;
    logic internalReset, portResetN;
    logic [1:0] startup_time_fuses;
    logic [3:0] cks, clr, status;
    int failures = 0;
    int tests_run = 0;
    int n;
    rsc_far_side far (.mclk(mclk), .supplyLow(supplyLow), .resetPinN(resetPinN),
        .watchdogExpire(wdExp), .lowSupplyCmp(lsCmp));
    reset_source_combiner dut (.mclk(mclk), .rst(rst), .supplyLow(supplyLow),
        .resetPinN(resetPinN), .watchdogExpire(wdExp), .watchdogEnable(wdEn),
        .lowSupplyCmp(lsCmp), .lowSupplyEnable(lsEn), .startupTimeFuses(startup_time_fuses),
        .clockSelectFuses(cks), .flagClear(clr), .internalReset(internalReset),
        .portResetN(portResetN), .resetCauseStatus(status));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic give_verdict();
        if (failures == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkSpan(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            failures++;
            $display("ERROR %0t span %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // cycles until internal reset is released
    task automatic waitRel(output int cyc);
        cyc = 0;
        while (internalReset !== 1'b0) begin
            @(posedge mclk);
            #1;
            cyc++;
            if (cyc > 2000) begin
                failures++;
                give_verdict();
            end
        end
    endtask
    task automatic clearFlags();
        @(posedge mclk);
        clr <= 4'hf;
        @(posedge mclk);
        clr <= 4'h0;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    // apply one cause, expect reset, stretch and flag
    task automatic cause(input int which, input int len, input int tout, input logic [3:0] fl);
        int i;
        far.hold(which, len);
        for (i = 0; i < 8 && internalReset !== 1'b1; i++) @(posedge mclk);
        #1;
        chk({3'h0, internalReset}, 4'h1);
        chk({3'h0, portResetN}, 4'h0);
        waitRel(n);
        chkSpan(n, tout - 2, tout + 10);
        @(posedge mclk);
        #1;
        chk({3'h0, portResetN}, 4'h1);
        chk(status, fl);
        clearFlags();
    endtask
    initial begin
        rst = 1'b1;
        wdEn = 1'b0;
        lsEn = 1'b0;
        startup_time_fuses = 2'h0;
        cks = 4'h0;
        clr = 4'h0;
        repeat (10) @(posedge mclk);
        #1;
        chk({internalReset, portResetN, 2'h0}, 4'h8);
        chk(status, 4'h0);
        @(posedge mclk);
        rst <= 1'b0;
        #1;
        waitRel(n);
        chkSpan(n, 16, 40);
        chk(status, 4'h1);
        clearFlags();
        chk(status, 4'h0);
        @(posedge mclk);
        far.drive(1, 1'b1);
        #1;
        chk({3'h0, portResetN}, 4'h0);
        @(posedge mclk);
        far.drive(1, 1'b0);
        repeat (2) @(posedge mclk);
        #1;
        chk({3'h0, portResetN}, 4'h1);
        far.hold(1, 40);
        far.hold(2, 1);
        far.hold(3, 100);
        repeat (20) @(posedge mclk);
        #1;
        chk({3'h0, internalReset}, 4'h0);
        @(posedge mclk);
        wdEn <= 1'b1;
        lsEn <= 1'b1;
        cause(1, 100, 16, 4'h2);
        cause(2, 1, 16, 4'h8);
        cause(3, 100, 16, 4'h4);
        cause(0, 5, 16, 4'h1);
        @(posedge mclk);
        startup_time_fuses <= 2'h1;
        cks <= 4'h2;
        cause(1, 100, 256, 4'h2);
        far.hold(1, 100);
        repeat (100) @(posedge mclk);
        #1;
        chk({3'h0, internalReset}, 4'h1);
        far.hold(0, 5);
        #1;
        waitRel(n);
        chkSpan(n, 256, 270);
        chk(status, 4'h1);
        give_verdict();
    end
endmodule
`default_nettype wire

/* File: test/rsc_far_side.sv */
// far side model: supply detectors, reset pin and watchdog
`timescale 1ns/1ps
`default_nettype none
module rsc_far_side (
    // clock
    input wire logic mclk,
    // causes
    output logic supplyLow,
    output logic resetPinN,
    output logic watchdogExpire,
    output logic lowSupplyCmp
);
    initial begin
        supplyLow = 1'b0;
        resetPinN = 1'b1;
        watchdogExpire = 1'b0;
        lowSupplyCmp = 1'b0;
    end
    // 0 supply, 1 pin, 2 watchdog, 3 low supply
    task automatic drive(input int which, input logic on);
        case (which)
            0: supplyLow <= on;
            1: resetPinN <= !on;
            2: watchdogExpire <= on;
            default: lowSupplyCmp <= on;
        endcase
    endtask
    // hold a cause active for n cycles
    task automatic hold(input int which, input int n);
        @(posedge mclk);
        drive(which, 1'b1);
        repeat (n) @(posedge mclk);
        drive(which, 1'b0);
    endtask
endmodule
`default_nettype wire
